// file: src/vector_output_clocking_defs.svh
// Constants for the vector output clocking core
`ifndef VECTOR_OUTPUT_CLOCKING_DEFS_SVH
`define VECTOR_OUTPUT_CLOCKING_DEFS_SVH

// Register indexes on the plain port
`define REG_CTRL 4'h0
`define REG_PERIOD 4'h1
`define REG_DELAY 4'h2
`define REG_INITLEN 4'h3
`define REG_STATUS 4'h4
`define REG_LABEL0 4'h8

// Control fields
`define CTRL_SRC_BIT 0
`define CTRL_MODE_BIT 1
`define CTRL_RANGE_LSB 2
`define CTRL_RUN_BIT 4

// Period fields: mantissa in tenths, decade exponent
`define PER_MANT_MSB 6
`define PER_EXP_LSB 8
`define PER_EXP_MSB 10
`define PER_MANT_RESET 7'h64
`define PER_EXP_RESET 3'h0

// Status fields
`define STAT_RUN_BIT 0
`define STAT_LABEL_ERR_BIT 1
`define STAT_PER_ADJ_BIT 2
`define STAT_RANGE_ADJ_BIT 3

// Timing, each value in the unit its name gives (ns, us, ps)
`define SYS_PERIOD_NS 50
`define MIN_PER_WIDE_NS 10
`define MIN_PER_NARROW_NS 5
`define MAX_PER_US 250
`define FAST_PER_NS 20
`define DELAY_STEP_PS 1300

`endif

// file: src/vector_output_clocking_pkg.sv
// Types for the vector output clocking core
package vector_output_clocking_pkg;

  typedef enum logic [0:0] {SRC_INTERNAL = 1'b0, SRC_EXTERNAL = 1'b1} clk_src_e;
  typedef enum logic [0:0] {MODE_WIDE = 1'b0, MODE_NARROW = 1'b1} out_mode_e;
  typedef enum logic [1:0] {RANGE_LOW = 2'b00, RANGE_MID = 2'b01, RANGE_HIGH = 2'b10} ext_range_e;

  // Internal period setting
  typedef struct packed {
    logic [6:0] mant;
    logic [2:0] expo;
  } period_s;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

endpackage : vector_output_clocking_pkg

// file: src/vector_output_clocking.sv
// Vector output clocking core: clock source, period, modes, pods, labels
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "vector_output_clocking_defs.svh"

module vector_output_clocking
  import vector_output_clocking_pkg::*;
#(
  parameter int NUM_LABELS = 4,
  parameter int DELAY_TAPS = 16
) (
  // System clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // External vector clock from the clock pod
  input wire logic clkLink,
  // Register port
  input wire reg_req_s regReq,
  output logic [31:0] regRdata_q,
  // Vector source
  input wire logic [31:0] vecIn,
  input wire logic vecValid,
  output logic vecTake_q,
  // Pod outputs
  output logic [31:0] podData_q,
  output logic [3:0] podEnable_q,
  output logic clkOut_q
);

  localparam int MIN_WIDE_T = `MIN_PER_WIDE_NS * 10;
  localparam int MIN_NARROW_T = `MIN_PER_NARROW_NS * 10;
  localparam int MAX_T = `MAX_PER_US * 10000;
  localparam int FAST_T = `FAST_PER_NS * 10;
  localparam int SYS_T = `SYS_PERIOD_NS * 10;
  localparam int DW = $clog2(DELAY_TAPS);

  // Period value in tenths of a nanosecond
  function automatic int perTenths(input period_s p);
    int v;
    v = int'(p.mant);
    for (int i = 0; i < 7; i++) begin
      if (i < int'(p.expo)) begin
        v = v * 10;
      end
    end
    return v;
  endfunction : perTenths

  // Nearest allowed mantissa step, ties go to the larger step
  function automatic logic [6:0] roundMant(input logic [6:0] m);
    logic [6:0] r;
    r = 7'h64;
    if (m < 7'h0f) begin
      r = 7'h0a;
    end else if (m < 7'h17) begin
      r = 7'h14;
    end else if (m < 7'h21) begin
      r = 7'h19;
    end else if (m < 7'h2d) begin
      r = 7'h28;
    end else if (m < 7'h41) begin
      r = 7'h32;
    end else if (m < 7'h5a) begin
      r = 7'h50;
    end
    return r;
  endfunction : roundMant

  // Limit a period to the mode's minimum and the common maximum
  function automatic period_s clampPer(input period_s p, input out_mode_e m);
    period_s r;
    int t;
    r = p;
    t = perTenths(p);
    if (m == MODE_WIDE && t < MIN_WIDE_T) begin
      r = '{mant: 7'h64, expo: 3'h0};
    end else if (m == MODE_NARROW && t < MIN_NARROW_T) begin
      r = '{mant: 7'h32, expo: 3'h0};
    end else if (t > MAX_T) begin
      r = '{mant: 7'h19, expo: 3'h5};
    end
    return r;
  endfunction : clampPer

  // Register state
  clk_src_e clkSrc_q;
  out_mode_e mode_q;
  ext_range_e range_q;
  logic run_q;
  period_s period_q;
  logic [DW-1:0] delay_q;
  logic [15:0] initLen_q;
  logic labelErr_q;
  logic perAdj_q;
  logic rangeAdj_q;
  logic [31:0] labelMask_q [NUM_LABELS];

  logic wrCtrl, wrPer, wrStat;
  out_mode_e newMode;
  ext_range_e newRange;
  period_s reqPer, newPer;

  assign wrCtrl = regReq.wr && regReq.addr == `REG_CTRL;
  assign wrPer = regReq.wr && regReq.addr == `REG_PERIOD;
  assign wrStat = regReq.wr && regReq.addr == `REG_STATUS;
  assign newMode = out_mode_e'(regReq.wdata[`CTRL_MODE_BIT]);
  assign reqPer = '{mant: roundMant(regReq.wdata[`PER_MANT_MSB:0]),
                    expo: regReq.wdata[`PER_EXP_MSB:`PER_EXP_LSB]};

  // Range choice legal for the mode: wide offers two, narrow three
  always_comb begin
    newRange = ext_range_e'(regReq.wdata[`CTRL_RANGE_LSB+1:`CTRL_RANGE_LSB]);
    if (regReq.wdata[`CTRL_RANGE_LSB+1:`CTRL_RANGE_LSB] == 2'b11) begin
      newRange = RANGE_HIGH;
    end
    // Checked after the unused code is folded, so wide never keeps the top range
    if (newRange == RANGE_HIGH && newMode == MODE_WIDE) begin
      newRange = RANGE_MID;
    end
  end

  // New period: on a period write, or re-checked when the mode changes
  always_comb begin
    newPer = period_q;
    if (wrPer) begin
      newPer = clampPer(reqPer, wrCtrl ? newMode : mode_q);
    end else if (wrCtrl && newMode != mode_q) begin
      newPer = clampPer(period_q, newMode);
    end
  end

  // Control register
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      clkSrc_q <= SRC_INTERNAL;
      mode_q <= MODE_WIDE;
      range_q <= RANGE_LOW;
      run_q <= 1'b0;
    end else if (wrCtrl) begin
      clkSrc_q <= clk_src_e'(regReq.wdata[`CTRL_SRC_BIT]);
      mode_q <= newMode;
      range_q <= newRange;
      run_q <= regReq.wdata[`CTRL_RUN_BIT];
    end
  end

  // Period, delay and init length registers
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      period_q <= '{mant: `PER_MANT_RESET, expo: `PER_EXP_RESET};
      delay_q <= '0;
      initLen_q <= 16'h0000;
    end else begin
      period_q <= newPer;
      if (regReq.wr && regReq.addr == `REG_DELAY) begin
        delay_q <= regReq.wdata[DW-1:0];
      end
      if (regReq.wr && regReq.addr == `REG_INITLEN) begin
        initLen_q <= regReq.wdata[15:0];
      end
    end
  end

  // Sticky status; hardware set wins over a write-one clear
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      perAdj_q <= 1'b0;
      rangeAdj_q <= 1'b0;
    end else begin
      perAdj_q <= (wrPer && newPer != reqPer) || (perAdj_q && !(wrStat && regReq.wdata[`STAT_PER_ADJ_BIT]));
      rangeAdj_q <= (wrCtrl && newRange != ext_range_e'(regReq.wdata[`CTRL_RANGE_LSB+1:`CTRL_RANGE_LSB]))
                    || (rangeAdj_q && !(wrStat && regReq.wdata[`STAT_RANGE_ADJ_BIT]));
    end
  end

  // Label masks; a write that overlaps another label is dropped
  logic [NUM_LABELS-1:0] labelHit, labelClash;
  logic labelWr, labelRej;
  genvar g;
  generate
    for (g = 0; g < NUM_LABELS; g++) begin : gLabel
      assign labelHit[g] = regReq.wr && regReq.addr == 4'(`REG_LABEL0 + g);
      assign labelClash[g] = !labelHit[g] && |(labelMask_q[g] & regReq.wdata);
      always_ff @(posedge clk_sys) begin
        if (!resetn) begin
          labelMask_q[g] <= 32'h00000000;
        end else if (labelHit[g] && !(|labelClash)) begin
          labelMask_q[g] <= regReq.wdata;
        end
      end
    end
  endgenerate
  assign labelWr = |labelHit;
  assign labelRej = labelWr && |labelClash;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      labelErr_q <= 1'b0;
    end else begin
      labelErr_q <= labelRej || (labelErr_q && !(wrStat && regReq.wdata[`STAT_LABEL_ERR_BIT]));
    end
  end

  // Read data, one cycle after the read strobe; unmapped reads zero
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      regRdata_q <= 32'h00000000;
    end else begin
      regRdata_q <= 32'h00000000;
      if (regReq.rd) begin
        if (regReq.addr == `REG_CTRL) begin
          regRdata_q <= {27'h0, run_q, range_q, mode_q, clkSrc_q};
        end else if (regReq.addr == `REG_PERIOD) begin
          regRdata_q <= {21'h0, period_q.expo, 1'b0, period_q.mant};
        end else if (regReq.addr == `REG_DELAY) begin
          regRdata_q <= 32'(delay_q);
        end else if (regReq.addr == `REG_INITLEN) begin
          regRdata_q <= {16'h0, initLen_q};
        end else if (regReq.addr == `REG_STATUS) begin
          regRdata_q <= {28'h0, rangeAdj_q, perAdj_q, labelErr_q, run_q};
        end
        for (int i = 0; i < NUM_LABELS; i++) begin
          if (regReq.addr == 4'(`REG_LABEL0 + i)) begin
            regRdata_q <= labelMask_q[i];
          end
        end
      end
    end
  end

  // Link domain: reset synchroniser and a toggle per rising clock edge
  logic [1:0] linkRst_q;
  logic linkTog_q;
  always_ff @(posedge clkLink) begin
    linkRst_q <= {linkRst_q[0], resetn};
  end
  always_ff @(posedge clkLink) begin
    if (!linkRst_q[1]) begin
      linkTog_q <= 1'b0;
    end else begin
      linkTog_q <= !linkTog_q;
    end
  end

  // Toggle crossing into the system domain; stages two and three are compared, stage one only feeds stage two
  logic togMeta_q, togSync_q, togSeen_q, extEdge;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      togMeta_q <= 1'b0;
      togSync_q <= 1'b0;
      togSeen_q <= 1'b0;
    end else begin
      togMeta_q <= linkTog_q;
      togSync_q <= togMeta_q;
      togSeen_q <= togSync_q;
    end
  end
  assign extEdge = togSync_q != togSeen_q;

  // Internal generator; two cycles at least so the source can follow
  logic [21:0] perCycles, perCnt_q;
  logic intEdge, tick;
  always_comb begin
    perCycles = 22'(perTenths(period_q) / SYS_T);
    if (perCycles < 22'h2) begin
      perCycles = 22'h2;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!resetn || !run_q || clkSrc_q != SRC_INTERNAL) begin
      perCnt_q <= 22'h1;
    end else if (perCnt_q >= perCycles) begin
      perCnt_q <= 22'h1;
    end else begin
      perCnt_q <= perCnt_q + 22'h1;
    end
  end
  assign intEdge = run_q && clkSrc_q == SRC_INTERNAL && perCnt_q >= perCycles;
  assign tick = run_q && (clkSrc_q == SRC_EXTERNAL ? extEdge : intEdge);

  // Padding of the init sequence by repeating its first vector
  logic [1:0] padLeft_q, padNeed, padNow;
  logic runSeen_q, fastWide;
  assign fastWide = clkSrc_q == SRC_EXTERNAL ? range_q != RANGE_LOW : perTenths(period_q) < FAST_T;
  always_comb begin
    padNeed = 2'h0;
    if (initLen_q != 16'h0000) begin
      if (mode_q == MODE_NARROW) begin
        padNeed = 2'(3'h4 - {1'b0, initLen_q[1:0]});
      end else if (fastWide) begin
        padNeed = {1'b0, initLen_q[0]};
      end
    end
  end
  // Count used in the cycle run rises, so an early outside edge still pads
  assign padNow = run_q && !runSeen_q ? padNeed : padLeft_q;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      runSeen_q <= 1'b0;
      padLeft_q <= 2'h0;
    end else begin
      runSeen_q <= run_q;
      if (tick && vecValid && padNow != 2'h0) begin
        padLeft_q <= padNow - 2'h1;
      end else begin
        padLeft_q <= padNow;
      end
    end
  end

  // Launch a vector at each rising edge of the active clock
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      podData_q <= 32'h00000000;
      podEnable_q <= 4'h0;
      vecTake_q <= 1'b0;
    end else begin
      podEnable_q <= mode_q == MODE_WIDE ? 4'hf : 4'h5;
      vecTake_q <= tick && vecValid && padNow == 2'h0;
      if (tick && vecValid) begin
        if (mode_q == MODE_WIDE) begin
          podData_q <= vecIn;
        end else begin
          podData_q <= {8'h00, vecIn[15:8], 8'h00, vecIn[7:0]};
        end
      end
    end
  end

  // Output clock delay line, one tap per delay step
  logic [DELAY_TAPS-1:0] clkLine_q;
  logic launch_q;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      launch_q <= 1'b0;
      clkLine_q <= '0;
      clkOut_q <= 1'b0;
    end else begin
      launch_q <= tick && vecValid;
      clkLine_q <= {clkLine_q[DELAY_TAPS-2:0], launch_q};
      clkOut_q <= delay_q == '0 ? launch_q : clkLine_q[delay_q - DW'(1)];
    end
  end

endmodule : vector_output_clocking

// file: test/vector_output_clocking_properties.sv
// Port checks for the vector output clocking core
`timescale 1ns/1ps
`include "vector_output_clocking_defs.svh"
module vector_output_clocking_properties
  import vector_output_clocking_pkg::*;
#(
  parameter int DELAY_TAPS = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Register port
  input wire reg_req_s regReq,
  input wire logic [31:0] regRdata_q,
  // Vector and pod side
  input wire logic vecTake_q,
  input wire logic [31:0] podData_q,
  input wire logic [3:0] podEnable_q,
  input wire logic clkOut_q
);
  localparam int MAX_LAT = DELAY_TAPS;
  logic rdPer_q;
  logic rdCtrl_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Which register the last cycle read, so read data can be judged
  always_ff @(posedge clk_sys) begin
    rdPer_q <= regReq.rd && regReq.addr == `REG_PERIOD;
    rdCtrl_q <= regReq.rd && regReq.addr == `REG_CTRL;
  end
  a_pods_by_mode: assert property ($past(resetn) |-> podEnable_q == 4'hf || podEnable_q == 4'h5)
    else $error("pod enables neither wide nor narrow");
  a_narrow_pods_idle: assert property (vecTake_q && podEnable_q == 4'h5 |->
    podData_q[15:8] == 8'h00 && podData_q[31:24] == 8'h00)
    else $error("unused pod driven in narrow mode");
  a_take_single: assert property (vecTake_q |=> !vecTake_q)
    else $error("vector take longer than one cycle");
  a_data_then_clock: assert property ($changed(podData_q) |-> ##[1:MAX_LAT] clkOut_q)
    else $error("new data without output clock");
  a_period_step: assert property (rdPer_q |->
    regRdata_q[6:0] inside {7'h0a, 7'h14, 7'h19, 7'h28, 7'h32, 7'h50, 7'h64})
    else $error("period mantissa off step");
  a_period_max: assert property (rdPer_q |->
    regRdata_q[10:8] < 3'h5 || regRdata_q[10:8] == 3'h5 && regRdata_q[6:0] <= 7'h19)
    else $error("period above maximum");
  a_wide_min: assert property (rdPer_q && podEnable_q == 4'hf |->
    regRdata_q[10:8] != 3'h0 || regRdata_q[6:0] == 7'h64)
    else $error("wide period below minimum");
  a_narrow_min: assert property (rdPer_q && podEnable_q == 4'h5 |->
    regRdata_q[10:8] != 3'h0 || regRdata_q[6:0] >= 7'h32)
    else $error("narrow period below minimum");
  a_range_legal: assert property (rdCtrl_q |->
    regRdata_q[3:2] != 2'b11 && (regRdata_q[1] || regRdata_q[3:2] != 2'b10))
    else $error("frequency range not offered in mode");
  c_narrow_launch: cover property (vecTake_q && podEnable_q == 4'h5);
  c_wide_launch: cover property (vecTake_q && podEnable_q == 4'hf);
  c_period_read: cover property (rdPer_q);
endmodule : vector_output_clocking_properties

// file: test/sut_model.sv
// System under test: bursty link clock and vector strobe capture
`timescale 1ns/1ps
module sut_model (
  // Control from bench
  input wire logic clkEn,
  input wire logic [15:0] gapNs,
  // Pod side
  input wire logic clk_sys,
  input wire logic clkOut_q,
  output logic clkLink,
  output int nSeen
);
  // One 32 ns cycle per frame; clock stands low between frames
  initial begin
    clkLink = 1'b0;
    #3;
    forever begin
      if (clkEn) begin
        clkLink = 1'b1;
        #16 clkLink = 1'b0;
        #16;
        #(gapNs);
      end else begin
        #7;
      end
    end
  end
  // Count strobes the target would capture
  initial begin
    nSeen = 0;
    forever begin
      @(posedge clk_sys);
      if (clkOut_q === 1'b1) nSeen++;
    end
  end
endmodule : sut_model

// file: test/vector_output_clocking_test.sv
// Self-checking bench for the vector output clocking core
`timescale 1ns/1ps
`include "vector_output_clocking_defs.svh"
module vector_output_clocking_test;
  import vector_output_clocking_pkg::*;
  logic clk_sys, resetn, clkLink, vecValid, vecTake_q, clkOut_q, extEn;
  reg_req_s regReq;
  logic [31:0] regRdata_q, vecIn, podData_q, rd;
  logic [3:0] podEnable_q;
  logic [15:0] gap;
  logic [31:0] vq[$];
  int errors, n_compared, idx, nSeen, cyc, lastTake, lastClk, seed, md, m, e;
  bit go;
  vector_output_clocking u_vector_output_clocking (.clk_sys(clk_sys), .resetn(resetn), .clkLink(clkLink),
    .regReq(regReq), .regRdata_q(regRdata_q), .vecIn(vecIn), .vecValid(vecValid), .vecTake_q(vecTake_q),
    .podData_q(podData_q), .podEnable_q(podEnable_q), .clkOut_q(clkOut_q));
  sut_model u_sut_model (.clkEn(extEn), .gapNs(gap), .clk_sys(clk_sys), .clkOut_q(clkOut_q), .clkLink(clkLink),
    .nSeen(nSeen));
  // 20 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, x);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regReq <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    regReq <= '0;
  endtask : wr
  task rdr(input logic [3:0] a);
    @(posedge clk_sys);
    regReq <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk_sys);
    regReq <= '0;
    #1 rd = regRdata_q;
  endtask : rdr
  // Expected stored period: round, then clamp
  function automatic logic [31:0] perExp(int m, int e, int n);
    m = m < 15 ? 10 : m < 23 ? 20 : m < 33 ? 25 : m < 45 ? 40 : m < 65 ? 50 : m < 90 ? 80 : 100;
    if (e > 5 || (e == 5 && m > 25)) begin
      m = 25;
      e = 5;
    end
    if (e == 0 && m < (n ? 50 : 100)) m = n ? 50 : 100;
    return (e << 8) | m;
  endfunction : perExp
  // Vector source; follows takes, scrambles data while not valid
  always @(posedge clk_sys) begin
    cyc++;
    if (clkOut_q === 1'b1) lastClk = cyc;
    if (vecTake_q === 1'b1) begin
      chk(podData_q, md ? {8'h0, vq[idx][15:8], 8'h0, vq[idx][7:0]} : vq[idx]);
      lastTake = cyc;
      idx++;
    end
    vecValid <= go && idx < vq.size();
    vecIn <= go && idx < vq.size() ? vq[idx] : ~vecIn;
  end
  // One run: padding and delay are worked out before it starts
  task run(input logic src, n, input logic [1:0] rg, input logic [10:0] per, input int len, nv, gp);
    int pad, d, s0;
    bit fw;
    md = n;
    d = $random(seed) & 15;
    fw = src ? rg != 0 : per[10:8] == 0 || (per[10:8] == 1 && per[6:0] < 20);
    pad = len == 0 ? 0 : n ? (4 - len % 4) % 4 : fw ? len % 2 : 0;
    vq.delete();
    repeat (nv) vq.push_back($random(seed));
    wr(`REG_DELAY, d);
    wr(`REG_INITLEN, len);
    wr(`REG_CTRL, {rg, n, src});
    wr(`REG_PERIOD, per);
    gap = gp;
    extEn = src;
    idx = 0;
    s0 = nSeen;
    go = 1;
    wr(`REG_CTRL, {1'b1, rg, n, src});
    for (int i = 0; i < 3000 && idx < nv; i++) @(posedge clk_sys);
    repeat (25) @(posedge clk_sys);
    go = 0;
    extEn = 0;
    wr(`REG_CTRL, {rg, n, src});
    chk(idx, nv);
    chk(nSeen - s0, nv + pad);
    chk(lastClk - lastTake, d + 1);
    chk(podEnable_q, n ? 4'h5 : 4'hf);
    $display("run src %0d mode %0d done", src, n);
  endtask : run
  task conclude;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  // Main sequence
  initial begin
    seed = 32'h18b61374;
    {errors, n_compared, cyc, md} = '0;
    go = 0;
    extEn = 1;
    gap = 16'd150;
    resetn = 1'b0;
    regReq = '0;
    vecIn = '0;
    vecValid = 1'b0;
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    extEn = 0;
    rdr(`REG_PERIOD);
    chk(rd, 32'h64);
    rdr(4'hf);
    chk(rd, 32'h0);
    for (int i = 0; i < 16; i++) begin
      m = 10 + ($random(seed) & 127) % 91;
      e = $random(seed) & 7;
      wr(`REG_CTRL, (i % 2) << 1);
      wr(`REG_PERIOD, {e[2:0], 1'b0, m[6:0]});
      rdr(`REG_PERIOD);
      chk(rd, perExp(m, e, i % 2));
    end
    wr(`REG_CTRL, 32'h2);
    wr(`REG_PERIOD, 32'h32);
    wr(`REG_CTRL, 32'h0);
    rdr(`REG_PERIOD);
    chk(rd, 32'h64);
    for (int i = 0; i < 8; i++) begin
      wr(`REG_CTRL, (i % 4) << 2 | (i / 4) << 1);
      rdr(`REG_CTRL);
      chk(rd[3:2], i % 4 > 1 + i / 4 ? 1 + i / 4 : i % 4);
    end
    rdr(`REG_STATUS);
    chk(rd[3], 1'b1);
    wr(`REG_LABEL0, 32'hff);
    wr(4'h9, 32'hff00);
    wr(4'ha, 32'h180);
    rdr(4'ha);
    chk(rd, 32'h0);
    rdr(`REG_STATUS);
    chk(rd[1], 1'b1);
    rdr(4'h9);
    chk(rd, 32'hff00);
    $display("register tests done");
    run(0, 0, 0, 11'h20a, $random(seed) & 7, 6, 150);
    run(0, 0, 0, 11'h064, $random(seed) & 7, 6, 150);
    run(0, 1, 0, 11'h20a, $random(seed) & 7, 6, 150);
    run(1, 0, 1, 11'h0, $random(seed) & 7, 6, 150);
    run(1, 1, 2, 11'h0, $random(seed) & 7, 5, 700);
    conclude();
  end
  // Hang guard: about 550 cycles expected, limit far above
  initial begin
    #500_000;
    errors++;
    conclude();
  end
endmodule : vector_output_clocking_test
bind vector_output_clocking vector_output_clocking_properties #(.DELAY_TAPS(DELAY_TAPS)) u_props (
  .clk_sys(clk_sys), .resetn(resetn), .regReq(regReq), .regRdata_q(regRdata_q), .vecTake_q(vecTake_q),
  .podData_q(podData_q), .podEnable_q(podEnable_q), .clkOut_q(clkOut_q));
